// file: inc/tpos_chan_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpos_map.svh"
interface tpos_chan_if;
  logic [`TPOS_TW-1:0] period;
  logic [`TPOS_TW-1:0] offset;
  logic [`TPOS_TW-1:0] on_ticks;
  logic load;
  logic hold;
  logic out;
  modport ctl (output period, output offset, output on_ticks, output load, output hold, input out);
  modport chan (input period, input offset, input on_ticks, input load, input hold, output out);
endinterface : tpos_chan_if
`default_nettype wire

// file: inc/tpos_map.svh
`ifndef TPOS_MAP_SVH
`define TPOS_MAP_SVH
// ====================================================================
// timing
`define TPOS_CLK_MHZ 25
`define TPOS_TICK_US 100
`define TPOS_TICK_CYC (`TPOS_TICK_US * `TPOS_CLK_MHZ)
`define TPOS_TICKS_PER_MS 17'h0000A
`define TPOS_TICKS_PER_S 21'h02710
`define TPOS_P_M2_TICKS 21'h003E8
`define TPOS_P_M1_TICKS 21'h007D0
`define TPOS_P_Z_TICKS 21'h01388
`define TPOS_RESTART_CYC 8'h10
// ====================================================================
// widths and values
`define TPOS_NCH 4
`define TPOS_TW 21
`define TPOS_MV_FULL 10'h3E8
`define TPOS_BAND_MAX 10'h1F4
`define TPOS_BAND_RST 10'h00A
`define TPOS_PER_RST 8'h02
`define TPOS_PER_LO 8'hFE
`define TPOS_PER_HI 8'h63
`define TPOS_PER_M1 8'hFF
`define TPOS_PER_Z 8'h00
`define TPOS_SPAN_RST 4'h0
`define TPOS_LIM_NONE 2'h0
`define TPOS_LIM_ONE 2'h1
// ====================================================================
// register map, byte address fields: group in bits 7:4, register in bits 3:2
`define TPOS_A_GRP_SYS 4'h0
`define TPOS_A_GRP_MV 4'h1
`define TPOS_A_GRP_BAND 4'h2
`define TPOS_A_GRP_PER 4'h3
`define TPOS_A_SYS_CTRL 2'h0
`define TPOS_A_SYS_STAT 2'h1
`define TPOS_A_SYS_LIMIT 2'h2
`define TPOS_A_SYS_SPAN 2'h3
// field positions
`define TPOS_CTRL_COMMIT 0
`define TPOS_MV_MSB 9
`define TPOS_MV_PID 16
`define TPOS_MV_EN 17
`define TPOS_LIM_MSB 1
`define TPOS_DLY_LSB 16
`define TPOS_DLY_MSB 27
`define TPOS_STAT_BUSY 0
`define TPOS_STAT_OUT_LSB 4
`define TPOS_STAT_OUT_MSB 7
`define TPOS_STAT_CNT_LSB 16
`define TPOS_STAT_CNT_MSB 23
`define TPOS_RESP_OKAY 2'b00
`define TPOS_RESP_SLVERR 2'b10
`endif

// file: inc/tpos_pkg.sv
`include "tpos_map.svh"
package tpos_pkg;
  // ==================================================================
  // types
  typedef enum logic [1:0] {
    TPOS_ST_IDLE = 2'b01,
    TPOS_ST_RESTART = 2'b10
  } tpos_state_t;

  typedef enum logic [2:0] {
    TPOS_G_CTRL, TPOS_G_STAT, TPOS_G_LIMIT, TPOS_G_SPAN,
    TPOS_G_MV, TPOS_G_BAND, TPOS_G_PER, TPOS_G_NONE
  } tpos_grp_t;

  typedef struct packed {
    tpos_grp_t grp;
    logic [1:0] ch;
  } tpos_sel_t;

  // ==================================================================
  // helpers
  function automatic tpos_sel_t tpos_decode(input logic [7:0] a);
    tpos_sel_t s;
    s.ch = a[3:2];
    s.grp = TPOS_G_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[7:4])
        `TPOS_A_GRP_SYS: begin
          case (a[3:2])
            `TPOS_A_SYS_CTRL: s.grp = TPOS_G_CTRL;
            `TPOS_A_SYS_STAT: s.grp = TPOS_G_STAT;
            `TPOS_A_SYS_LIMIT: s.grp = TPOS_G_LIMIT;
            default: s.grp = TPOS_G_SPAN;
          endcase
        end
        `TPOS_A_GRP_MV: s.grp = TPOS_G_MV;
        `TPOS_A_GRP_BAND: s.grp = TPOS_G_BAND;
        `TPOS_A_GRP_PER: s.grp = TPOS_G_PER;
        default: s.grp = TPOS_G_NONE;
      endcase
    end
    return s;
  endfunction : tpos_decode

  function automatic logic [31:0] tpos_wmerge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : tpos_wmerge

  // period code to 100 us ticks
  function automatic logic [`TPOS_TW-1:0] tpos_per_ticks(input logic [7:0] code);
    logic [`TPOS_TW-1:0] t;
    case (code)
      `TPOS_PER_LO: t = `TPOS_P_M2_TICKS;
      `TPOS_PER_M1: t = `TPOS_P_M1_TICKS;
      `TPOS_PER_Z: t = `TPOS_P_Z_TICKS;
      default: t = `TPOS_TW'({14'h0000, code[6:0]}) * `TPOS_TICKS_PER_S;
    endcase
    return t;
  endfunction : tpos_per_ticks
endpackage : tpos_pkg

// file: logic/tpos_chan.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpos_map.svh"
module tpos_chan (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  tpos_chan_if.chan cif
);
  logic [`TPOS_TW-1:0] cnt_q;
  logic [`TPOS_TW-1:0] on_q;
  logic out_q;

  // ==================================================================
  // period counter; on time latched only at period start and on load so a moving
  // mv never chops a pulse in the middle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      on_q <= '0;
    end else if (cif.load) begin
      cnt_q <= cif.offset;
      on_q <= cif.on_ticks;
    end else if (tick) begin
      if (cnt_q >= cif.period - `TPOS_TW'(1)) begin
        cnt_q <= '0;
        on_q <= cif.on_ticks;
      end else begin
        cnt_q <= cnt_q + `TPOS_TW'(1);
      end
    end
  end

  // on for the first on_q ticks of each period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= 1'b0;
    end else begin
      out_q <= !cif.hold && (cnt_q < on_q);
    end
  end

  assign cif.out = out_q;
endmodule : tpos_chan
`default_nettype wire

// file: logic/tpos_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpos_map.svh"
module tpos_top #(
  parameter logic SSR_VARIANT = 1'b1,
  parameter logic STD_CONTROL = 1'b1,
  parameter logic FOUR_CH = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [`TPOS_NCH-1:0] ctrl_out,
  output logic [`TPOS_NCH-1:0] span_sel,
  output logic restart_busy
);
  // ==================================================================
  // axi4-lite write path
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_fire;
  tpos_pkg::tpos_sel_t wsel, rsel;

  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign wsel = tpos_pkg::tpos_decode(awaddr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `TPOS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wsel.grp == tpos_pkg::TPOS_G_NONE || wsel.grp == tpos_pkg::TPOS_G_STAT) ?
                 `TPOS_RESP_SLVERR : `TPOS_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ==================================================================
  // live registers: mv, pid mode, channel enable
  logic [9:0] mv_q [`TPOS_NCH];
  logic [`TPOS_NCH-1:0] pid_q, en_q;
  logic [31:0] mv_new;

  assign mv_new = tpos_pkg::tpos_wmerge({14'h0000, en_q[wsel.ch], pid_q[wsel.ch], 6'h00, mv_q[wsel.ch]},
                                        wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `TPOS_NCH; i++) begin
        mv_q[i] <= 10'h000;
      end
      pid_q <= '0;
      en_q <= '0;
    end else if (wr_fire && wsel.grp == tpos_pkg::TPOS_G_MV) begin
      // mv above full scale is clamped, not refused
      mv_q[wsel.ch] <= (mv_new[`TPOS_MV_MSB:0] > `TPOS_MV_FULL) ? `TPOS_MV_FULL : mv_new[`TPOS_MV_MSB:0];
      pid_q[wsel.ch] <= mv_new[`TPOS_MV_PID];
      en_q[wsel.ch] <= mv_new[`TPOS_MV_EN];
    end
  end

  // ==================================================================
  // staged settings; out of range values are dropped, old value kept
  logic [9:0] band_stg_q [`TPOS_NCH];
  logic [7:0] per_stg_q [`TPOS_NCH];
  logic [3:0] span_stg_q;
  logic [1:0] lim_stg_q;
  logic [11:0] dly_stg_q;
  logic [31:0] st_new;

  always_comb begin
    st_new = 32'h00000000;
    unique case (wsel.grp)
      tpos_pkg::TPOS_G_BAND: st_new = tpos_pkg::tpos_wmerge({22'h000000, band_stg_q[wsel.ch]}, wdata_q, wstrb_q);
      tpos_pkg::TPOS_G_PER: st_new = tpos_pkg::tpos_wmerge({24'h000000, per_stg_q[wsel.ch]}, wdata_q, wstrb_q);
      tpos_pkg::TPOS_G_SPAN: st_new = tpos_pkg::tpos_wmerge({28'h0000000, span_stg_q}, wdata_q, wstrb_q);
      tpos_pkg::TPOS_G_LIMIT: st_new = tpos_pkg::tpos_wmerge({4'h0, dly_stg_q, 14'h0000, lim_stg_q},
                                                            wdata_q, wstrb_q);
      default: st_new = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `TPOS_NCH; i++) begin
        band_stg_q[i] <= `TPOS_BAND_RST;
        per_stg_q[i] <= `TPOS_PER_RST;
      end
      span_stg_q <= `TPOS_SPAN_RST;
      lim_stg_q <= `TPOS_LIM_NONE;
      dly_stg_q <= 12'h000;
    end else if (wr_fire) begin
      if (wsel.grp == tpos_pkg::TPOS_G_BAND && st_new[9:0] <= `TPOS_BAND_MAX && st_new[31:10] == 22'h000000) begin
        band_stg_q[wsel.ch] <= st_new[9:0];
      end
      if (wsel.grp == tpos_pkg::TPOS_G_PER && $signed(st_new[7:0]) >= $signed(`TPOS_PER_LO) &&
          $signed(st_new[7:0]) <= $signed(`TPOS_PER_HI)) begin
        per_stg_q[wsel.ch] <= st_new[7:0];
      end
      if (wsel.grp == tpos_pkg::TPOS_G_SPAN) begin
        span_stg_q <= st_new[3:0];
      end
      if (wsel.grp == tpos_pkg::TPOS_G_LIMIT) begin
        lim_stg_q <= st_new[`TPOS_LIM_MSB:0];
        dly_stg_q <= st_new[`TPOS_DLY_MSB:`TPOS_DLY_LSB];
      end
    end
  end

  // ==================================================================
  // restart sequencer: commit holds outputs off, then loads staged values
  tpos_pkg::tpos_state_t state_q;
  logic [7:0] rst_cnt_q, restarts_q;
  logic load_q, apply;

  assign apply = (state_q == tpos_pkg::TPOS_ST_RESTART) && (rst_cnt_q == 8'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= tpos_pkg::TPOS_ST_IDLE;
      rst_cnt_q <= 8'h00;
      restarts_q <= 8'h00;
      load_q <= 1'b0;
    end else begin
      load_q <= apply;
      unique case (state_q)
        tpos_pkg::TPOS_ST_IDLE: begin
          if (wr_fire && wsel.grp == tpos_pkg::TPOS_G_CTRL && wstrb_q[0] && wdata_q[`TPOS_CTRL_COMMIT]) begin
            state_q <= tpos_pkg::TPOS_ST_RESTART;
            rst_cnt_q <= `TPOS_RESTART_CYC - 8'h01;
          end
        end
        tpos_pkg::TPOS_ST_RESTART: begin
          if (apply) begin
            state_q <= tpos_pkg::TPOS_ST_IDLE;
            restarts_q <= restarts_q + 8'h01;
          end else begin
            rst_cnt_q <= rst_cnt_q - 8'h01;
          end
        end
      endcase
    end
  end

  // active copies change only here, never on the register write itself
  logic [9:0] band_q [`TPOS_NCH];
  logic [7:0] per_q [`TPOS_NCH];
  logic [3:0] span_q;
  logic [1:0] lim_q;
  logic [11:0] dly_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `TPOS_NCH; i++) begin
        band_q[i] <= `TPOS_BAND_RST;
        per_q[i] <= `TPOS_PER_RST;
      end
      span_q <= `TPOS_SPAN_RST;
      lim_q <= `TPOS_LIM_NONE;
      dly_q <= 12'h000;
    end else if (apply) begin
      band_q <= band_stg_q;
      per_q <= per_stg_q;
      span_q <= span_stg_q;
      lim_q <= lim_stg_q;
      dly_q <= dly_stg_q;
    end
  end

  assign restart_busy = (state_q == tpos_pkg::TPOS_ST_RESTART);
  // span only drives the current stage on the linear variant
  assign span_sel = SSR_VARIANT ? 4'h0 : span_q;

  // ==================================================================
  // 100 us time base
  logic [11:0] div_q;
  logic tick;

  assign tick = (div_q == 12'(`TPOS_TICK_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 12'h000;
    end else begin
      div_q <= tick ? 12'h000 : div_q + 12'h001;
    end
  end

  // ==================================================================
  // limiter: shared period from channel 0, phase slots and mv cap
  logic lim_on;
  logic [`TPOS_TW-1:0] dly_ticks, per_all, slot, cap_base, cap;

  // on two channel units the 3 and 2 output settings act as no restriction
  assign lim_on = SSR_VARIANT && STD_CONTROL && (lim_q != `TPOS_LIM_NONE) &&
                  (FOUR_CH || lim_q == `TPOS_LIM_ONE);
  assign dly_ticks = `TPOS_TW'({5'h00, dly_q} * `TPOS_TICKS_PER_MS);
  // each channel gets one delay slot of off time added to the period
  assign per_all = tpos_pkg::tpos_per_ticks(per_q[0]) +
                   (FOUR_CH ? (dly_ticks << 2) : (dly_ticks << 1));
  assign slot = FOUR_CH ? (per_all >> 2) : (per_all >> 1);
  assign cap_base = FOUR_CH ? `TPOS_TW'(slot * `TPOS_TW'(lim_q)) : slot;
  assign cap = (cap_base > dly_ticks) ? cap_base - dly_ticks : '0;

  // ==================================================================
  // channels
  tpos_chan_if cif [`TPOS_NCH] ();

  for (genvar k = 0; k < `TPOS_NCH; k++) begin : g_ch
    logic live, band_act;
    logic [9:0] mv_in, mv_eff;
    logic [`TPOS_TW-1:0] per_k, on_raw;
    logic [30:0] prod;

    assign live = en_q[k] && (FOUR_CH || k < 2);
    assign mv_in = live ? mv_q[k] : 10'h000;
    assign band_act = SSR_VARIANT && pid_q[k];
    always_comb begin
      if (band_act && mv_in < band_q[k]) begin
        mv_eff = 10'h000;
      end else if (band_act && mv_in > `TPOS_MV_FULL - band_q[k]) begin
        mv_eff = `TPOS_MV_FULL;
      end else begin
        mv_eff = mv_in;
      end
    end

    assign per_k = lim_on ? per_all : tpos_pkg::tpos_per_ticks(per_q[k]);
    assign prod = 31'(per_k) * 31'(mv_eff);
    assign on_raw = `TPOS_TW'(prod / 31'(`TPOS_MV_FULL));
    assign cif[k].period = per_k;
    assign cif[k].offset = (lim_on && k != 0) ? per_all - `TPOS_TW'(slot * `TPOS_TW'(k)) : '0;
    assign cif[k].on_ticks = (lim_on && pid_q[k] && on_raw > cap) ? cap : on_raw;
    assign cif[k].load = load_q;
    assign cif[k].hold = restart_busy;
    assign ctrl_out[k] = cif[k].out;

    tpos_chan u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .cif(cif[k])
    );
  end

  // ==================================================================
  // axi4-lite read path
  assign rsel = tpos_pkg::tpos_decode(s_axi_araddr);
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `TPOS_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= `TPOS_RESP_OKAY;
      rdata_q <= 32'h00000000;
      unique case (rsel.grp)
        tpos_pkg::TPOS_G_CTRL: rdata_q <= 32'h00000000;
        tpos_pkg::TPOS_G_STAT: begin
          rdata_q[`TPOS_STAT_BUSY] <= restart_busy;
          rdata_q[`TPOS_STAT_OUT_MSB:`TPOS_STAT_OUT_LSB] <= ctrl_out;
          rdata_q[`TPOS_STAT_CNT_MSB:`TPOS_STAT_CNT_LSB] <= restarts_q;
        end
        tpos_pkg::TPOS_G_LIMIT: rdata_q <= {4'h0, dly_stg_q, 14'h0000, lim_stg_q};
        tpos_pkg::TPOS_G_SPAN: rdata_q <= {28'h0000000, span_stg_q};
        tpos_pkg::TPOS_G_MV: rdata_q <= {14'h0000, en_q[rsel.ch], pid_q[rsel.ch], 6'h00, mv_q[rsel.ch]};
        tpos_pkg::TPOS_G_BAND: rdata_q <= {22'h000000, band_stg_q[rsel.ch]};
        tpos_pkg::TPOS_G_PER: rdata_q <= {24'h000000, per_stg_q[rsel.ch]};
        tpos_pkg::TPOS_G_NONE: rresp_q <= `TPOS_RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule : tpos_top
`default_nettype wire

// file: testbench/time_proportional_output_shaper_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpos_map.svh"
module time_proportional_output_shaper_tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, b, obs, e;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, snap = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0] bresp, rresp;
  logic [3:0] ctrl_out, span_sel, energized;
  logic [27:0] on_cnt0;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h0000A56E;
  string what;
  int n_errors = 0, tests_run = 0, cyc = 0, t0 = 0;
  always #20 aclk = ~aclk;
  tpos_top u_tpos_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ctrl_out(ctrl_out),
    .span_sel(span_sel), .restart_busy(busy));
  tpos_ssr_load u_tpos_ssr_load (.aclk(aclk), .aresetn(aresetn), .drive(ctrl_out), .energized(energized),
    .on_cnt0(on_cnt0));
  // ==========
  // closing
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  // whole run needs about 34000 cycles after the restart
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      $display("Error timeout expected 0 seen %0d", cyc);
      test_done();
    end
  end
  // ==========
  // result monitor
  always @(posedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready) || snap) begin
      if (snap) begin
        what = "outputs";
        obs = {on_cnt0[19:0], span_sel, energized, ctrl_out};
      end else if (bvalid && bready) begin
        what = "bresp";
        obs = {30'h0, bresp};
      end else begin
        what = "rdata";
        obs = rdata;
      end
      tests_run++;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hDEADBEEF;
      if (obs !== e) begin
        n_errors++;
        $display("Error %s expected %h seen %h", what, e, obs);
      end
    end
  end
  // ==========
  // stimulus
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    exp_q.push_back({30'h0, r});
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'h1) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready === 1'h1) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end
    bready <= 1'h1;
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    exp_q.push_back(d);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rready <= 1'h0;
    // let an edge pass so a following read never re-raises rready in this time step
    @(posedge aclk);
  endtask : rd
  // the on-count of load 0 rides along, so every look also checks it stayed dark
  task automatic look(input int t, input logic [3:0] o);
    while (cyc < t0 + t) @(posedge aclk);
    exp_q.push_back({24'h0, o, o});
    snap <= 1'h1;
    @(posedge aclk);
    snap <= 1'h0;
  endtask : look
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(8'h20, 32'h0000000A);
    rd(8'h30, 32'h00000002);
    rd(8'hF0, 32'h00000000);
    wr(8'h04, 32'h00000001, 4'hF, `TPOS_RESP_SLVERR);
    rd(8'h04, 32'h00000000);
    $display("test defaults done");
    for (int k = 0; k < 4; k++) begin
      b = rnd() % 32'h000001F5;
      wr({4'h2, k[1:0], 2'h0}, b, 4'hF, `TPOS_RESP_OKAY);
      wr({4'h2, k[1:0], 2'h0}, 32'h000001F5, 4'hF, `TPOS_RESP_OKAY);
      rd({4'h2, k[1:0], 2'h0}, b);
      wr({4'h2, k[1:0], 2'h0}, 32'h0000000A, 4'hF, `TPOS_RESP_OKAY);
      wr({4'h3, k[1:0], 2'h0}, 32'h000000FE, 4'hF, `TPOS_RESP_OKAY);
      rd({4'h3, k[1:0], 2'h0}, 32'h000000FE);
    end
    $display("test band range done");
    wr(8'h10, 32'h00030005, 4'hF, `TPOS_RESP_OKAY);
    wr(8'h14, 32'h000303E3, 4'hF, `TPOS_RESP_OKAY);
    wr(8'h18, 32'h0003000C, 4'hF, `TPOS_RESP_OKAY);
    wr(8'h1C, 32'h00020005, 4'hF, `TPOS_RESP_OKAY);
    wr(8'h00, 32'h00000001, 4'h1, `TPOS_RESP_OKAY);
    do @(posedge aclk); while (busy !== 1'h0);
    t0 = cyc;
    look(200, 4'hE);
    rd(8'h04, 32'h000100E0);
    $display("test restart done");
    // a wide band staged on channel 2 must not reach the output before the next restart
    wr(8'h28, 32'h000001F4, 4'hF, `TPOS_RESP_OKAY);
    // tick phase against the restart is unknown, so looks keep a full tick clear
    look(9000, 4'hE);
    look(16000, 4'h6);
    look(26000, 4'h6);
    look(33000, 4'h2);
    $display("test on time done");
    // one output at a time: shifted channels start mid period and stay dark
    wr(8'h2C, 32'h00000000, 4'hF, `TPOS_RESP_OKAY);
    wr(8'h08, 32'h00000001, 4'hF, `TPOS_RESP_OKAY);
    wr(8'h00, 32'h00000001, 4'h1, `TPOS_RESP_OKAY);
    do @(posedge aclk); while (busy !== 1'h0);
    t0 = cyc;
    look(200, 4'h0);
    $display("test limiter done");
    test_done();
  end
endmodule : time_proportional_output_shaper_tb_top
`default_nettype wire

// file: testbench/tpos_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpos_map.svh"
module tpos_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`TPOS_NCH-1:0] ctrl_out,
  input wire logic [`TPOS_NCH-1:0] span_sel,
  input wire logic restart_busy
);
  // ==========
  // bus handshake
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  aw_hold_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("aw accepted twice");
  w_hold_a: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready) else $error("w accepted twice");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
    |-> ##2 s_axi_bvalid) else $error("write response late");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  // a new address or data beat taken on the response edge legally holds its ready low
  b_release_a: assert property (s_axi_bvalid && s_axi_bready && s_axi_awready && s_axi_wready && !s_axi_awvalid
    && !s_axi_wvalid |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write channel not freed");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read data dropped");
  // ==========
  // restart
  restart_len_a: assert property ($rose(restart_busy) |-> restart_busy [*8] ##1 restart_busy [*8] ##1 !restart_busy)
    else $error("restart length wrong");
  // outputs must stay off while staged settings are copied
  out_quiet_a: assert property (restart_busy && $past(restart_busy) |-> ctrl_out == '0)
    else $error("output on during restart");
  span_commit_a: assert property ($changed(span_sel) |-> $fell(restart_busy))
    else $error("span changed outside restart");
  cover property ($fell(restart_busy));
  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == `TPOS_RESP_SLVERR);
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `TPOS_RESP_SLVERR);
  cover property ($fell(ctrl_out[2]));
endmodule : tpos_assertions
bind tpos_top tpos_assertions u_tpos_assertions (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ctrl_out(ctrl_out), .span_sel(span_sel), .restart_busy(restart_busy));
`default_nettype wire

// file: testbench/tpos_ssr_load.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpos_map.svh"
module tpos_ssr_load #(
  parameter int ON_DLY = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`TPOS_NCH-1:0] drive,
  output logic [`TPOS_NCH-1:0] energized,
  output logic [27:0] on_cnt0
);
  // ==========
  // relay with a slow pull-in, drops out at once
  logic [7:0] dly_q [`TPOS_NCH];
  always_ff @(posedge aclk) begin
    for (int k = 0; k < `TPOS_NCH; k++) begin
      if (!aresetn || !drive[k]) begin
        dly_q[k] <= 8'h00;
      end else if (dly_q[k] != 8'hFF) begin
        dly_q[k] <= dly_q[k] + 8'h01;
      end
    end
  end
  always_comb begin
    for (int k = 0; k < `TPOS_NCH; k++) begin
      energized[k] = int'(dly_q[k]) >= ON_DLY;
    end
  end
  // energy seen by load 0, which must never pull in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_cnt0 <= 28'h0000000;
    end else if (energized[0]) begin
      on_cnt0 <= on_cnt0 + 28'h0000001;
    end
  end
endmodule : tpos_ssr_load
`default_nettype wire
